// ==== src/adc_fifo_pkg.sv ====
// Constants, register map and field layout of the converter FIFO control
//
// Notes on behaviour
// - Bit 7 and bits 4-3 of the FIFO control register read zero, ignore writes.
// - Scan on with FIFO active repeats the first queued channel until results fill.
// - Scan with continuous conversion restarts the same channel once complete is set.
// - Combine select 0: complete flag needs at least one compare trigger in the set.
// - Combine select 1: complete flag needs every compare trigger of the set.
// - Depth field zero disables the FIFO; plain single conversions are done.
// - Nonzero depth field enables the FIFO with depth of field plus one.
// - With FIFO on, channel writes push and result pair reads pop.
// - In FIFO mode conversion starts only once queued channels reach the depth.
// - In FIFO mode complete is set only when the result FIFO holds the depth.
// - Result reads in FIFO mode return results in the order channels were queued.
// - Input clock select code 11 picks the asynchronous converter clock.
package adc_fifo_pkg;

    // Register byte offsets, one word each
    localparam logic [7:0] OFS_FIFO_CTRL = 8'h00;
    localparam logic [7:0] OFS_STAT_CTRL1 = 8'h04;
    localparam logic [7:0] OFS_CLK_CFG = 8'h08;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'h0C;
    localparam logic [7:0] OFS_RESULT_LOW = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
    localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
    localparam logic [7:0] OFS_IRQ_ENABLE = 8'h1C;

    // FIFO control register fields
    localparam int SCAN_BIT = 6;
    localparam int COMB_BIT = 5;
    localparam int DEPTH_LSB = 0;
    localparam int DEPTH_W = 3;

    // Status and control one fields
    localparam int CHAN_LSB = 0;
    localparam int CHAN_W = 5;
    localparam int CONT_BIT = 5;
    localparam int CMPEN_BIT = 6;
    localparam int CONVERSION_COMPLETE_FLAG_BIT = 7;

    // Clock configuration
    localparam int CLKSEL_W = 2;
    localparam logic [1:0] ASYNC_SEL = 2'h3;

    // Interrupt events
    localparam int EV_CONVERSION_COMPLETE_FLAG = 0;
    localparam int EV_CMP = 1;
    localparam int EV_W = 2;

    // Result layout and FIFO sizing
    localparam int RES_W = 12;
    localparam int RES_HI_W = 4;
    localparam int LVL_W = 4;
    localparam int MAX_LEVELS = 8;

    // Reset values
    localparam logic [DEPTH_W-1:0] RST_DEPTH = 3'h0;
    localparam logic [CHAN_W-1:0] RST_CHAN = 5'h1F;
    localparam logic [CLKSEL_W-1:0] RST_CLKSEL = 2'h0;
    localparam logic [EV_W-1:0] RST_IRQ = 2'h0;
    localparam logic [31:0] RST_RDATA = 32'h0000_0000;

endpackage

// ==== src/adc_fifo_scan_compare_control.sv ====
// FIFO, scan and compare-combine control of the converter, AHB-Lite slave
`timescale 1ns/1ps
module adc_fifo_scan_compare_control (
    input wire logic core_clk_i, // 50 MHz clock
    input wire logic rst_i, // Synchronous reset, high
    input wire logic hsel_i, // Slave select
    input wire logic [31:0] haddr_i, // Byte address
    input wire logic [1:0] htrans_i, // Transfer type
    input wire logic hwrite_i, // Write when high
    input wire logic [2:0] hsize_i, // Word only
    input wire logic [31:0] hwdata_i, // Write data
    input wire logic hready_i, // Bus ready
    output logic [31:0] hrdata_o, // Read data
    output logic hreadyout_o, // Slave ready
    output logic hresp_o, // Always OKAY
    input wire logic conv_done_i, // Converter finished, pulse
    input wire logic [adc_fifo_pkg::RES_W-1:0] conv_result_i, // Result
    input wire logic cmp_trig_i, // Compare met, with done
    output logic conv_start_o, // Start a conversion, pulse
    output logic [adc_fifo_pkg::CHAN_W-1:0] conv_chan_o, // Channel
    output logic [adc_fifo_pkg::CLKSEL_W-1:0] clk_sel_o, // Clock source
    output logic async_clk_sel_o, // Async clock chosen
    output logic irq_o // Interrupt level
);
    import adc_fifo_pkg::*;

    typedef enum logic {ST_IDLE, ST_BUSY} seq_t;

    // Levels for a depth code, zero when the FIFO is off
    function automatic logic [LVL_W-1:0] levels(input logic [DEPTH_W-1:0] d);
        levels = (d == '0) ? '0 : LVL_W'({1'b0, d} + 4'h1);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state, writes land in the data phase

    logic pend_q;
    logic pwr_q;
    logic [7:0] a_q;
    logic hready_q;
    logic hresp_q;
    logic [31:0] hrdata_q;
    logic accept;
    logic wr_en;
    logic rd_en;

    assign accept = hsel_i & htrans_i[1] & hready_i;
    assign wr_en = pend_q & pwr_q;
    assign rd_en = pend_q & ~pwr_q;

    // Address phase capture; upper address bits are not decoded
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
            pwr_q <= 1'b0;
            a_q <= 8'h00;
            hready_q <= 1'b1;
            hresp_q <= 1'b0;
        end else begin
            pend_q <= accept;
            hready_q <= ~accept;
            hresp_q <= 1'b0;
            if (accept) begin
                a_q <= haddr_i[7:0];
                pwr_q <= hwrite_i;
            end
        end
    end

    logic wr_ctrl;
    logic wr_sc1;
    logic wr_clk;
    logic wr_iclr;
    logic wr_ien;
    logic rd_rl;

    assign wr_ctrl = wr_en & (a_q == OFS_FIFO_CTRL);
    assign wr_sc1 = wr_en & (a_q == OFS_STAT_CTRL1);
    assign wr_clk = wr_en & (a_q == OFS_CLK_CFG);
    assign wr_iclr = wr_en & (a_q == OFS_IRQ_CLEAR);
    assign wr_ien = wr_en & (a_q == OFS_IRQ_ENABLE);
    assign rd_rl = rd_en & (a_q == OFS_RESULT_LOW);

    ////////////////////////////////////////////////////////////////////////
    // Software registers

    logic scan_q;
    logic comb_q;
    logic [DEPTH_W-1:0] depth_q;
    logic [CHAN_W-1:0] chan_q;
    logic cont_q;
    logic cmp_en_q;
    logic [CLKSEL_W-1:0] clk_sel_q;
    logic async_q;
    logic [EV_W-1:0] irq_en_q;

    // Reserved control bits are simply never stored
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            scan_q <= 1'b0;
            comb_q <= 1'b0;
            depth_q <= RST_DEPTH;
            chan_q <= RST_CHAN;
            cont_q <= 1'b0;
            cmp_en_q <= 1'b0;
            clk_sel_q <= RST_CLKSEL;
            async_q <= 1'b0;
            irq_en_q <= RST_IRQ;
        end else begin
            if (wr_ctrl) begin
                scan_q <= hwdata_i[SCAN_BIT];
                comb_q <= hwdata_i[COMB_BIT];
                depth_q <= hwdata_i[DEPTH_LSB +: DEPTH_W];
            end
            if (wr_sc1) begin
                chan_q <= hwdata_i[CHAN_LSB +: CHAN_W];
                cont_q <= hwdata_i[CONT_BIT];
                cmp_en_q <= hwdata_i[CMPEN_BIT];
            end
            if (wr_clk) begin
                clk_sel_q <= hwdata_i[CLKSEL_W-1:0];
                async_q <= (hwdata_i[CLKSEL_W-1:0] == ASYNC_SEL);
            end
            if (wr_ien) begin
                irq_en_q <= hwdata_i[EV_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel queue, result queue and conversion sequencer

    seq_t st_q;
    logic [LVL_W-1:0] chan_cnt_q;
    logic [LVL_W-1:0] res_cnt_q;
    logic [2:0] conv_idx_q;
    logic [2:0] res_rd_q;
    logic cmp_or_q;
    logic cmp_and_q;
    logic conv_start_q;
    logic [CHAN_W-1:0] conv_chan_q;
    logic [CHAN_W-1:0] chan_mem [MAX_LEVELS];
    logic [RES_W-1:0] res_mem [MAX_LEVELS];

    logic [LVL_W-1:0] lvl;
    logic fifo_on;
    logic busy;
    logic push;
    logic pop;
    logic last;
    logic cmp_or_n;
    logic cmp_and_n;
    logic set_ok;
    logic single_ok;
    logic done_ev;
    logic conversion_complete_flag_ev;
    logic res_we;
    logic [2:0] res_wa;
    logic fifo_go;
    logic next_go;
    logic single_go;
    logic cont_go;
    logic start_ev;
    logic [CHAN_W-1:0] start_chan;

    assign lvl = levels(depth_q);
    assign fifo_on = (lvl != '0);
    assign busy = (st_q == ST_BUSY);
    assign push = wr_sc1 & fifo_on & (chan_cnt_q < lvl);
    assign pop = rd_rl & fifo_on & ({1'b0, res_rd_q} < res_cnt_q);
    assign last = fifo_on & (LVL_W'(res_cnt_q + 4'h1) == lvl);
    assign cmp_or_n = cmp_or_q | cmp_trig_i;
    assign cmp_and_n = cmp_and_q & cmp_trig_i;
    // Without compare every finished set counts as complete
    assign set_ok = ~cmp_en_q | (comb_q ? cmp_and_n : cmp_or_n);
    assign single_ok = ~cmp_en_q | cmp_trig_i;
    assign done_ev = busy & conv_done_i & ~wr_ctrl;
    assign conversion_complete_flag_ev = done_ev & (fifo_on ? (last & set_ok) : single_ok);
    assign res_we = done_ev & (fifo_on ? (res_cnt_q < lvl) : single_ok);
    assign res_wa = fifo_on ? res_cnt_q[2:0] : 3'h0;
    // A set starts once the queue is full and old results are done with
    assign fifo_go = ~busy & fifo_on & ~wr_ctrl & (chan_cnt_q == lvl)
        & ((res_cnt_q == '0) | (res_cnt_q == lvl));
    assign next_go = done_ev & fifo_on & ~last;
    assign single_go = ~fifo_on & wr_sc1;
    assign cont_go = done_ev & ~fifo_on & cont_q;
    assign start_ev = fifo_go | next_go | single_go | cont_go;

    // Channel for the conversion about to start
    always_comb begin
        start_chan = chan_q;
        if (single_go) begin
            start_chan = hwdata_i[CHAN_LSB +: CHAN_W];
        end else if (fifo_on) begin
            if (scan_q | fifo_go) begin
                start_chan = chan_mem[0];
            end else begin
                start_chan = chan_mem[3'(conv_idx_q + 3'h1)];
            end
        end
    end

    // Sequencer; a depth write aborts everything in flight
    always_ff @(posedge core_clk_i) begin
        if (rst_i || wr_ctrl) begin
            st_q <= ST_IDLE;
            chan_cnt_q <= '0;
            res_cnt_q <= '0;
            conv_idx_q <= 3'h0;
            res_rd_q <= 3'h0;
            cmp_or_q <= 1'b0;
            cmp_and_q <= 1'b1;
        end else begin
            if (push) begin
                chan_cnt_q <= LVL_W'(chan_cnt_q + 4'h1);
            end
            if (pop) begin
                res_rd_q <= 3'(res_rd_q + 3'h1);
            end
            if (done_ev) begin
                if (fifo_on) begin
                    res_cnt_q <= LVL_W'(res_cnt_q + 4'h1);
                    conv_idx_q <= 3'(conv_idx_q + 3'h1);
                    cmp_or_q <= cmp_or_n;
                    cmp_and_q <= cmp_and_n;
                    if (last) begin
                        st_q <= ST_IDLE;
                        // Continuous keeps the queue for the next set
                        if (!cont_q) begin
                            chan_cnt_q <= '0;
                        end
                    end
                end else begin
                    st_q <= cont_q ? ST_BUSY : ST_IDLE;
                end
            end
            if (fifo_go) begin
                st_q <= ST_BUSY;
                res_cnt_q <= '0;
                res_rd_q <= 3'h0;
                conv_idx_q <= 3'h0;
                cmp_or_q <= 1'b0;
                cmp_and_q <= 1'b1;
            end
            if (single_go) begin
                st_q <= ST_BUSY;
            end
        end
    end

    // Start strobe and channel towards the converter
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            conv_start_q <= 1'b0;
            conv_chan_q <= RST_CHAN;
        end else begin
            conv_start_q <= start_ev & ~wr_ctrl;
            if (start_ev) begin
                conv_chan_q <= start_chan;
            end
        end
    end

    // Queue storage; no reset needed, pointers guard the contents
    always_ff @(posedge core_clk_i) begin
        if (push) begin
            chan_mem[chan_cnt_q[2:0]] <= hwdata_i[CHAN_LSB +: CHAN_W];
        end
        if (res_we) begin
            res_mem[res_wa] <= conv_result_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Conversion complete flag and interrupts

    logic conversion_complete_flag_q;
    logic conversion_complete_flag_clr;
    logic [EV_W-1:0] irq_st_q;
    logic [EV_W-1:0] irq_st_d;
    logic [EV_W-1:0] irq_ev;
    logic irq_q;

    // Cleared by a new channel write, a FIFO control write or by draining the results
    assign conversion_complete_flag_clr = wr_sc1 | wr_ctrl
        | (rd_rl & (~fifo_on | (LVL_W'(res_rd_q + 4'h1) >= res_cnt_q)));

    // A completion in the clearing cycle wins over the clear
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            conversion_complete_flag_q <= 1'b0;
        end else if (conversion_complete_flag_ev) begin
            conversion_complete_flag_q <= 1'b1;
        end else if (conversion_complete_flag_clr) begin
            conversion_complete_flag_q <= 1'b0;
        end
    end

    assign irq_ev[EV_CONVERSION_COMPLETE_FLAG] = conversion_complete_flag_ev;
    assign irq_ev[EV_CMP] = done_ev & cmp_trig_i;
    assign irq_st_d = (irq_st_q & ~(wr_iclr ? hwdata_i[EV_W-1:0] : RST_IRQ))
        | irq_ev;

    // Sticky status; the line follows next state to save a cycle
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_st_q <= RST_IRQ;
            irq_q <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            irq_q <= |(irq_st_d & irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data

    logic [31:0] rd_mux;
    logic [RES_W-1:0] res_head;

    assign res_head = res_mem[res_rd_q];

    // Unmapped and write-only words read zero
    always_comb begin
        rd_mux = RST_RDATA;
        unique case (a_q)
            OFS_FIFO_CTRL: begin
                rd_mux[SCAN_BIT] = scan_q;
                rd_mux[COMB_BIT] = comb_q;
                rd_mux[DEPTH_LSB +: DEPTH_W] = depth_q;
            end
            OFS_STAT_CTRL1: begin
                rd_mux[CHAN_LSB +: CHAN_W] = chan_q;
                rd_mux[CONT_BIT] = cont_q;
                rd_mux[CMPEN_BIT] = cmp_en_q;
                rd_mux[CONVERSION_COMPLETE_FLAG_BIT] = conversion_complete_flag_q;
            end
            OFS_CLK_CFG: rd_mux[CLKSEL_W-1:0] = clk_sel_q;
            OFS_RESULT_HIGH: rd_mux[RES_HI_W-1:0] = res_head[RES_W-1:8];
            OFS_RESULT_LOW: rd_mux[7:0] = res_head[7:0];
            OFS_IRQ_STATUS: rd_mux[EV_W-1:0] = irq_st_q;
            OFS_IRQ_ENABLE: rd_mux[EV_W-1:0] = irq_en_q;
            default: rd_mux = RST_RDATA;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            hrdata_q <= RST_RDATA;
        end else if (rd_en) begin
            hrdata_q <= rd_mux;
        end
    end

    assign hrdata_o = hrdata_q;
    assign hreadyout_o = hready_q;
    assign hresp_o = hresp_q;
    assign conv_start_o = conv_start_q;
    assign conv_chan_o = conv_chan_q;
    assign clk_sel_o = clk_sel_q;
    assign async_clk_sel_o = async_q;
    assign irq_o = irq_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence bus_wait_s;
        !hreadyout_o ##1 hreadyout_o;
    endsequence

    bus_answer_a: assert property (accept |=> bus_wait_s)
        else $error("bus answer not after one wait state");

    ctrl_reserved_a: assert property (
        rd_en && a_q == OFS_FIFO_CTRL |=> hrdata_o[7] == 1'b0
        && hrdata_o[4:3] == 2'h0 && hrdata_o[31:8] == 24'h0)
        else $error("reserved control bits not zero");

    scan_channel_a: assert property (
        next_go && scan_q |=> conv_start_o && conv_chan_o == chan_mem[0])
        else $error("scan did not reuse first channel");

    // A refused compare restarts too, but leaves the flag alone
    cont_restart_a: assert property (
        cont_go |=> conv_start_o && conv_chan_o == $past(chan_q)
        && (conversion_complete_flag_q || !$past(single_ok)))
        else $error("continuous restart missing");

    scan_restart_a: assert property (
        $rose(conversion_complete_flag_q) && fifo_on && scan_q && cont_q && !wr_ctrl
        |=> conv_start_o && conv_chan_o == chan_mem[0])
        else $error("scan set not restarted on first channel");

    or_combine_a: assert property (
        conversion_complete_flag_ev && fifo_on && cmp_en_q && !comb_q |-> cmp_or_n)
        else $error("OR combine set flag without trigger");

    and_combine_a: assert property (
        conversion_complete_flag_ev && fifo_on && cmp_en_q && comb_q |-> cmp_and_q && cmp_trig_i)
        else $error("AND combine set flag with a trigger missing");

    single_start_a: assert property (
        single_go |=> conv_start_o && busy
        && conv_chan_o == $past(hwdata_i[CHAN_LSB +: CHAN_W]))
        else $error("single conversion not started");

    depth_levels_a: assert property (
        depth_q != '0 |-> lvl == {1'b0, depth_q} + 4'h1)
        else $error("depth code maps to wrong level count");

    fifo_start_a: assert property (
        $rose(busy) && fifo_on |-> $past(chan_cnt_q) == lvl)
        else $error("set started before queue was full");

    set_complete_a: assert property (
        $rose(conversion_complete_flag_q) && fifo_on |-> res_cnt_q == lvl)
        else $error("complete flag before result FIFO full");

    depth_flush_a: assert property (
        wr_ctrl |=> chan_cnt_q == '0 && res_cnt_q == '0 && !busy)
        else $error("depth write did not flush");

    result_pop_a: assert property (
        pop && !fifo_go |=> res_rd_q == 3'($past(res_rd_q) + 3'h1))
        else $error("result read did not pop");

endmodule // adc_fifo_scan_compare_control

// ==== tb/adc_fifo_scan_compare_control_bench.sv ====
// Self-checking bench for the converter FIFO, scan and compare control
`timescale 1ns/1ps
module adc_fifo_scan_compare_control_bench;
import adc_fifo_pkg::*;

logic core_clk_i = 1'b0;
logic rst_i = 1'b1;
logic hsel = 1'b0;
logic [31:0] haddr = 32'h0;
logic [1:0] htrans = 2'h0;
logic hwrite = 1'b0;
logic [2:0] hsize = 3'h2;
logic [31:0] hwdata = 32'h0;
logic conv_done = 1'b0;
logic [RES_W-1:0] conv_result = 12'h000;
logic cmp_trig = 1'b0;
logic [31:0] hrdata_o;
logic hreadyout_o;
logic hresp_o;
logic conv_start_o;
logic [CHAN_W-1:0] conv_chan_o;
logic [CLKSEL_W-1:0] clk_sel_o;
logic async_clk_sel_o;
logic irq_o;
int fails = 0;
int n_checks = 0;
int n_starts = 0;
int seen_starts = 0;
logic [CHAN_W-1:0] last_chan = 5'h00;

adc_fifo_scan_compare_control adc_fifo_scan_compare_control_i (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .conv_done_i(conv_done), .conv_result_i(conv_result),
    .cmp_trig_i(cmp_trig), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .clk_sel_o(clk_sel_o),
    .async_clk_sel_o(async_clk_sel_o), .irq_o(irq_o)
);

// 50 MHz clock
always #10 core_clk_i = ~core_clk_i;

// Count start pulses; NBA keeps tasks seeing a settled count
always @(posedge core_clk_i) begin
    if (conv_start_o === 1'b1) begin
        n_starts <= n_starts + 1;
        last_chan <= conv_chan_o;
    end
end

////////////////////////////////////////////////////////////////////////////
// Shared tasks

task automatic summarize();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
        $display("NO MISMATCHES");
    end else begin
        $display("MISMATCHES SEEN");
    end
    $finish;
endtask

task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
        fails++;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

task automatic idle(input int n);
    repeat (n) @(posedge core_clk_i);
endtask

// One AHB-Lite single word transfer; waits on sampled hready both phases
task automatic bus(input logic wr, input logic [7:0] a,
                   input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge core_clk_i);
    while (hreadyout_o !== 1'b1 && n < 50) begin
        @(posedge core_clk_i);
        n++;
    end
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
        @(posedge core_clk_i);
        n++;
    end while (hreadyout_o !== 1'b1 && n < 50);
    rd = hrdata_o;
    chk(32'(hresp_o), 32'h0);
    if (n >= 50) begin
        fails++;
        summarize();
    end
endtask

task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
endtask

task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, exp);
endtask

// Waits for the next start pulse, bounded, and checks its channel
task automatic wait_start(input logic [CHAN_W-1:0] ch);
    int n;
    n = 0;
    do begin
        @(posedge core_clk_i);
        n++;
    end while (n_starts == seen_starts && n < 60);
    if (n >= 60) begin
        fails++;
        summarize();
    end
    seen_starts = n_starts;
    chk(32'(last_chan), 32'(ch));
endtask

// Converter done pulse; never two in a row, so the bus clock stays faster
task automatic done(input logic [RES_W-1:0] r, input logic t);
    conv_done <= 1'b1;
    conv_result <= r;
    cmp_trig <= t;
    @(posedge core_clk_i);
    conv_done <= 1'b0;
endtask

function automatic logic [CHAN_W-1:0] chan_of(input int i);
    return 5'(i * 3 + 2);
endfunction

function automatic logic [RES_W-1:0] res_of(input int i);
    return {4'(i + 1), 8'(8'h30 + i)};
endfunction

////////////////////////////////////////////////////////////////////////////
// Scenarios

// Reset values, reserved bits, clock select, unmapped address
task automatic regs_case();
    rdchk(OFS_FIFO_CTRL, 32'h0000_0000);
    rdchk(OFS_STAT_CTRL1, 32'h0000_001F);
    wr(OFS_FIFO_CTRL, 32'h0000_00FF);
    rdchk(OFS_FIFO_CTRL, 32'h0000_0067);
    wr(OFS_FIFO_CTRL, 32'h0000_0000);
    wr(OFS_CLK_CFG, 32'h0000_0003);
    idle(2);
    chk(32'(async_clk_sel_o), 32'h1);
    chk(32'(clk_sel_o), 32'h3);
    wr(OFS_CLK_CFG, 32'h0000_0002);
    idle(2);
    chk(32'(async_clk_sel_o), 32'h0);
    rdchk(8'h40, 32'h0000_0000);
endtask

// Single conversion with depth zero, then interrupt mask and clear
task automatic single_case();
    seen_starts = n_starts;
    wr(OFS_STAT_CTRL1, 32'h0000_0005);
    wait_start(5'h05);
    done(12'hABC, 1'b0);
    idle(2);
    rdchk(OFS_STAT_CTRL1, 32'h0000_0085);
    rdchk(OFS_RESULT_HIGH, 32'h0000_000A);
    rdchk(OFS_RESULT_LOW, 32'h0000_00BC);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0001);
    chk(32'(irq_o), 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    idle(3);
    chk(32'(irq_o), 32'h1);
    wr(OFS_IRQ_ENABLE, 32'h0000_0000);
    idle(3);
    chk(32'(irq_o), 32'h0);
    wr(OFS_IRQ_ENABLE, 32'h0000_0001);
    wr(OFS_IRQ_CLEAR, 32'h0000_0003);
    idle(3);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0000);
    chk(32'(irq_o), 32'h0);
endtask

// Single continuous restart; a missed compare keeps the old result
task automatic cont_single_case();
    seen_starts = n_starts;
    wr(OFS_STAT_CTRL1, 32'h0000_0064);
    wait_start(5'h04);
    done(12'h5A5, 1'b1);
    wait_start(5'h04);
    idle(2);
    rdchk(OFS_IRQ_STATUS, 32'h0000_0003);
    chk(32'(irq_o), 32'h1);
    rdchk(OFS_RESULT_LOW, 32'h0000_00A5);
    done(12'h777, 1'b0);
    wait_start(5'h04);
    rdchk(OFS_RESULT_LOW, 32'h0000_00A5);
    rdchk(OFS_STAT_CTRL1, 32'h0000_0064);
    wr(OFS_STAT_CTRL1, 32'h0000_0004);
    done(12'h123, 1'b0);
    idle(2);
    rdchk(OFS_RESULT_LOW, 32'h0000_0023);
endtask

// Depth rewrite discards queued channels
task automatic flush_case();
    int s0;
    wr(OFS_FIFO_CTRL, 32'h0000_0002);
    seen_starts = n_starts;
    s0 = n_starts;
    wr(OFS_STAT_CTRL1, 32'h0000_0007);
    wr(OFS_STAT_CTRL1, 32'h0000_0008);
    wr(OFS_FIFO_CTRL, 32'h0000_0002);
    wr(OFS_STAT_CTRL1, 32'h0000_0009);
    wr(OFS_STAT_CTRL1, 32'h0000_000A);
    idle(4);
    chk(32'(n_starts), 32'(s0));
    wr(OFS_STAT_CTRL1, 32'h0000_000B);
    wait_start(5'h09);
    done(12'h111, 1'b0);
    wait_start(5'h0A);
    done(12'h222, 1'b0);
    wait_start(5'h0B);
    done(12'h333, 1'b0);
    idle(2);
endtask

// One FIFO set: queue, hold-off, start order, complete flag, pops
task automatic run_set(input logic [2:0] dep, input logic scan,
                       input logic comb, input logic cmpen,
                       input logic cont, input logic [7:0] trig,
                       input logic conversion_complete_flag);
    int lv;
    int s0;
    logic [31:0] x;
    lv = int'(dep) + 1;
    wr(OFS_FIFO_CTRL, {25'h0, scan, comb, 2'h0, dep});
    seen_starts = n_starts;
    s0 = n_starts;
    for (int i = 0; i < lv; i++) begin
        wr(OFS_STAT_CTRL1, {25'h0, cmpen, cont, chan_of(i)});
        if (i == lv - 2) begin
            idle(4);
            chk(32'(n_starts), 32'(s0));
        end
    end
    for (int i = 0; i < lv; i++) begin
        wait_start(scan ? chan_of(0) : chan_of(i));
        if (i == lv - 1) begin
            bus(1'b0, OFS_STAT_CTRL1, 32'h0, x);
            chk(32'(x[CONVERSION_COMPLETE_FLAG_BIT]), 32'h0);
        end
        done(res_of(i), trig[i]);
    end
    idle(2);
    bus(1'b0, OFS_STAT_CTRL1, 32'h0, x);
    chk(32'(x[CONVERSION_COMPLETE_FLAG_BIT]), 32'(conversion_complete_flag));
    if (cont) begin
        wait_start(chan_of(0));
        done(res_of(0), 1'b0);
        wr(OFS_FIFO_CTRL, 32'h0000_0000);
        done(res_of(1), 1'b0);
        idle(2);
        rdchk(OFS_STAT_CTRL1, 32'h0000_0025);
    end else if (!cmpen) begin
        for (int i = 0; i < lv; i++) begin
            rdchk(OFS_RESULT_HIGH, 32'(res_of(i) >> 8));
            rdchk(OFS_RESULT_LOW, 32'(res_of(i) & 12'h0FF));
        end
    end
endtask

////////////////////////////////////////////////////////////////////////////
// Main sequence

initial begin
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    regs_case();
    single_case();
    cont_single_case();
    flush_case();
    run_set(3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1);
    run_set(3'h7, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1);
    run_set(3'h3, 1'b0, 1'b0, 1'b1, 1'b0, 8'h04, 1'b1);
    run_set(3'h2, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
    run_set(3'h2, 1'b0, 1'b1, 1'b1, 1'b0, 8'h05, 1'b0);
    run_set(3'h2, 1'b0, 1'b1, 1'b1, 1'b0, 8'h07, 1'b1);
    run_set(3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00, 1'b1);
    run_set(3'h1, 1'b1, 1'b0, 1'b0, 1'b1, 8'h00, 1'b1);
    idle(4);
    summarize();
end

endmodule // adc_fifo_scan_compare_control_bench
